// ### src/dram_mode_register_bank.sv
// mode register bank: latency, drive, temperature, identity, burst order
// assumes a decoded mode command each cycle and an async sensor code
`timescale 1ns/1ps
`default_nettype none
module dram_mode_register_bank
  import dram_mode_pkg::*;
#(
  parameter logic [7:0] MAKER_ID    = 8'h5A, // arbitrary value
  parameter logic [7:0] REVISION_ID = 8'h3C  // arbitrary value
) (
  input  wire logic       clock_in,
  input  wire logic       reset_in,
  input  wire mode_cmd_t  command_in,
  output var mode_rdata_t read_out,
  input  wire logic [2:0] sensor_code_in,
  input  wire logic       burst_start_in,
  input  wire logic [3:1] column_in,
  output logic [3:0]      burst_column_out,
  output logic            burst_valid_out,
  output logic            burst_illegal_out,
  output logic [3:0]      latency_config_out,
  output logic [3:0]      drive_strength_out,
  output logic            derate_out,
  output logic            limit_error_out,
  output logic            hot_out
);

  logic [3:0]   latency_q;
  logic [3:0]   drive_q;
  logic [4:0]   burst_cfg_q;
  logic [2:0]   sense_meta_q;
  logic [2:0]   code_q;
  logic [2:0]   code_seen_q;
  logic         tuf_q;
  burst_state_t state_q;
  logic [3:0]   base_q;
  logic [3:0]   beat_q;
  logic [3:0]   mask_q;
  logic         ilv_q;
  logic         nowrap_q;
  logic         wr_en;
  logic         rd_en;
  logic         temp_read;
  logic         lat_ok;
  logic         drive_ok;
  logic         len_ok;
  logic [3:0]   start_col;
  logic [3:0]   cfg_mask;
  logic         start_legal;

  // command qualifiers
  assign wr_en     = command_in.write;
  assign rd_en     = command_in.read;
  assign temp_read = rd_en && command_in.address == ADDR_TEMP;

  // reserved codes are screened before any store
  assign lat_ok   = command_in.opcode[CODE_MSB:0] != CODE_ZERO
                 && command_in.opcode[CODE_MSB:0] <= LAT_MAX;
  assign drive_ok = command_in.opcode[CODE_MSB:0] >= DRIVE_MIN
                 && command_in.opcode[CODE_MSB:0] <= DRIVE_MAX
                 && command_in.opcode[CODE_MSB:0] != DRIVE_HOLE;
  assign len_ok   = command_in.opcode[2:0] == BL4
                 || command_in.opcode[2:0] == BL8
                 || command_in.opcode[2:0] == BL16;

  // latency register, upper opcode bits dropped
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      latency_q <= LAT_RESET;
    end else if (wr_en && command_in.address == ADDR_LATENCY && lat_ok) begin
      latency_q <= command_in.opcode[CODE_MSB:0];
    end
  end

  // drive strength register
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      drive_q <= DRIVE_RESET;
    end else if (wr_en && command_in.address == ADDR_DRIVE && drive_ok) begin
      drive_q <= command_in.opcode[CODE_MSB:0];
    end
  end

  // burst config: length, type, wrap; a reserved length drops the write
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      burst_cfg_q <= BURST_RESET;
    end else if (wr_en && command_in.address == ADDR_BURST && len_ok) begin
      burst_cfg_q <= command_in.opcode[WC_BIT:0];
    end
  end

  // sensor code crosses in from its own timing, two flops first
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      sense_meta_q <= REF_NOMINAL;
      code_q       <= REF_NOMINAL;
    end else begin
      sense_meta_q <= sensor_code_in;
      code_q       <= sense_meta_q;
    end
  end

  // update flag: a change in the same cycle as a read wins over the clear
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      tuf_q       <= 1'b0;
      code_seen_q <= REF_NOMINAL;
    end else begin
      code_seen_q <= code_q;
      if (code_q != code_seen_q) begin
        tuf_q <= 1'b1;
      end else if (temp_read) begin
        tuf_q <= 1'b0;
      end
    end
  end

  // temperature status decodes for the controller's timing logic
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      derate_out      <= 1'b0;
      limit_error_out <= 1'b0;
      hot_out         <= 1'b0;
    end else begin
      derate_out      <= code_q == REF_QTR_DERATE;
      limit_error_out <= code_q == REF_LOW_LIMIT
                      || code_q == REF_HIGH_LIMIT;
      hot_out         <= code_q[HOT_BIT];
    end
  end

  // read answer one cycle after the command; write-only and unmapped give 00h
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      read_out <= '0;
    end else begin
      read_out.valid <= rd_en;
      case (command_in.address)
        ADDR_TEMP:     read_out.data <= {tuf_q, 4'h0, code_q};
        ADDR_MAKER:    read_out.data <= MAKER_ID;
        ADDR_REVISION: read_out.data <= REVISION_ID;
        default:       read_out.data <= ZERO_BYTE;
      endcase
    end
  end

  // register mirrors for the datapath
  assign latency_config_out = latency_q;
  assign drive_strength_out = drive_q;

  // start column with bit zero forced low
  assign start_col = {column_in, 1'b0};

  // address span per length
  always_comb begin
    case (burst_cfg_q[2:0])
      BL4:     cfg_mask = MASK4;
      BL8:     cfg_mask = MASK8;
      BL16:    cfg_mask = MASK16;
      default: cfg_mask = MASK4;
    endcase
  end

  // no-wrap only at 4 beats; 16 beats sequential wrap only
  assign start_legal = burst_cfg_q[2:0] == BL4
                    || (burst_cfg_q[2:0] == BL8 && !burst_cfg_q[WC_BIT])
                    || (burst_cfg_q[2:0] == BL16 && !burst_cfg_q[WC_BIT]
                        && !burst_cfg_q[BT_BIT]);

  // column of a beat: no-wrap adds, interleave xors, sequential wraps
  function automatic logic [3:0] beat_col(
    input logic [3:0] base,
    input logic [3:0] beat,
    input logic [3:0] mask,
    input logic       ilv,
    input logic       nowrap
  );
    logic [3:0] sum;
    sum = base + beat;
    if (nowrap) begin
      beat_col = sum;
    end else if (ilv) begin
      beat_col = base ^ beat;
    end else begin
      beat_col = (base & ~mask) | (sum & mask);
    end
  endfunction

  // burst sequencer; starts while a burst runs are ignored
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_q           <= BURST_IDLE;
      base_q            <= 4'h0;
      beat_q            <= 4'h0;
      mask_q            <= MASK4;
      ilv_q             <= 1'b0;
      nowrap_q          <= 1'b0;
      burst_column_out  <= 4'h0;
      burst_valid_out   <= 1'b0;
      burst_illegal_out <= 1'b0;
    end else begin
      burst_illegal_out <= 1'b0;
      case (state_q)
        BURST_IDLE: begin
          if (burst_start_in && start_legal) begin
            state_q          <= BURST_RUN;
            base_q           <= start_col;
            beat_q           <= 4'h0;
            mask_q           <= cfg_mask;
            ilv_q            <= burst_cfg_q[BT_BIT];
            nowrap_q         <= burst_cfg_q[WC_BIT];
            burst_column_out <= start_col;
            burst_valid_out  <= 1'b1;
          end else if (burst_start_in) begin
            burst_illegal_out <= 1'b1;
          end
        end
        BURST_RUN: begin
          if (beat_q == mask_q) begin
            state_q         <= BURST_IDLE;
            burst_valid_out <= 1'b0;
          end else begin
            beat_q           <= beat_q + BEAT_ONE;
            burst_column_out <= beat_col(base_q, beat_q + BEAT_ONE,
                                         mask_q, ilv_q, nowrap_q);
          end
        end
        default: begin
          state_q         <= BURST_IDLE;
          burst_valid_out <= 1'b0;
        end
      endcase
    end
  end

  // checks kept beside the logic they guard
  sequence bl4_start_s;
    state_q == BURST_IDLE && burst_start_in
      && burst_cfg_q[2:0] == BL4 && !burst_cfg_q[WC_BIT];
  endsequence

  sequence bl4_run_s;
    (burst_valid_out && burst_column_out[3:2] == base_q[3:2])[*4]
      ##1 !burst_valid_out;
  endsequence

  bl4_span_a: assert property (@(posedge clock_in) disable iff (reset_in)
    bl4_start_s |=> bl4_run_s)
    else $error("4-beat burst left its 4-column span");

  seq16_step_a: assert property (@(posedge clock_in) disable iff (reset_in)
    burst_valid_out && state_q == BURST_RUN && mask_q == MASK16
      && beat_q != mask_q
      |=> burst_column_out == $past(burst_column_out) + BEAT_ONE)
    else $error("16-beat burst did not ascend modulo 16");

  start_even_a: assert property (@(posedge clock_in) disable iff (reset_in)
    state_q == BURST_IDLE && burst_start_in && start_legal
      |=> burst_valid_out && !burst_column_out[0])
    else $error("burst began at an odd column");

  latency_store_a: assert property (@(posedge clock_in) disable iff (reset_in)
    wr_en && command_in.address == ADDR_LATENCY
      |=> latency_config_out == ($past(lat_ok)
          ? $past(command_in.opcode[CODE_MSB:0]) : $past(latency_q)))
    else $error("latency register wrong after write");

  drive_store_a: assert property (@(posedge clock_in) disable iff (reset_in)
    wr_en && command_in.address == ADDR_DRIVE && !drive_ok
      |=> $stable(drive_strength_out))
    else $error("reserved drive code was stored");

  tuf_set_a: assert property (@(posedge clock_in) disable iff (reset_in)
    code_q != code_seen_q |=> tuf_q ##1 (!$past(temp_read) || read_out.data[TUF_BIT]))
    else $error("update flag missed a code change");

  tuf_clear_a: assert property (@(posedge clock_in) disable iff (reset_in)
    temp_read && code_q == code_seen_q |=> !tuf_q)
    else $error("temperature read did not clear update flag");

  tuf_reset_a: assert property (@(posedge clock_in)
    reset_in |=> !tuf_q)
    else $error("update flag set after reset");

  temp_read_a: assert property (@(posedge clock_in) disable iff (reset_in)
    temp_read |=> read_out.valid && read_out.data[2:0] == $past(code_q))
    else $error("temperature read returned wrong code");

  hot_flag_a: assert property (@(posedge clock_in) disable iff (reset_in)
    code_q[HOT_BIT] ##1 code_q[HOT_BIT] |-> hot_out)
    else $error("hot flag low with code bit 2 set");

  maker_read_a: assert property (@(posedge clock_in) disable iff (reset_in)
    rd_en && command_in.address == ADDR_MAKER
      |=> read_out.valid && read_out.data == MAKER_ID)
    else $error("maker identity read wrong");

  error_flag_a: assert property (@(posedge clock_in) disable iff (reset_in)
    code_q == REF_HIGH_LIMIT |=> limit_error_out)
    else $error("limit error not flagged");

endmodule
`default_nettype wire

// ### src/dram_mode_pkg.sv
// constants and carrier types for the mode register bank
// assumes one 250 MHz command clock shared by every user
package dram_mode_pkg;
  // mode addresses
  localparam logic [7:0] ADDR_BURST    = 8'h01;
  localparam logic [7:0] ADDR_LATENCY  = 8'h02;
  localparam logic [7:0] ADDR_DRIVE    = 8'h03;
  localparam logic [7:0] ADDR_TEMP     = 8'h04;
  localparam logic [7:0] ADDR_MAKER    = 8'h05;
  localparam logic [7:0] ADDR_REVISION = 8'h06;
  // field layout
  localparam int CODE_MSB = 3;
  localparam int TUF_BIT  = 7;
  localparam int HOT_BIT  = 2;
  localparam int BT_BIT   = 3;
  localparam int WC_BIT   = 4;
  // reset values and legal ranges
  localparam logic [3:0] LAT_RESET   = 4'h1;
  localparam logic [3:0] LAT_MAX     = 4'h6;
  localparam logic [3:0] DRIVE_RESET = 4'h2;
  localparam logic [3:0] DRIVE_MIN   = 4'h1;
  localparam logic [3:0] DRIVE_HOLE  = 4'h5;
  localparam logic [3:0] DRIVE_MAX   = 4'h7;
  localparam logic [3:0] CODE_ZERO   = 4'h0;
  // burst length codes
  localparam logic [2:0] BL4  = 3'h2;
  localparam logic [2:0] BL8  = 3'h3;
  localparam logic [2:0] BL16 = 3'h4;
  localparam logic [3:0] MASK4  = 4'h3;
  localparam logic [3:0] MASK8  = 4'h7;
  localparam logic [3:0] MASK16 = 4'hF;
  localparam logic [3:0] BEAT_ONE = 4'h1;
  localparam logic [4:0] BURST_RESET = 5'h02;
  // refresh-rate codes
  localparam logic [2:0] REF_LOW_LIMIT  = 3'h0;
  localparam logic [2:0] REF_QTR_DERATE = 3'h6;
  localparam logic [2:0] REF_HIGH_LIMIT = 3'h7;
  localparam logic [2:0] REF_NOMINAL    = 3'h3;
  // derating time and its cycle count, rounded up
  localparam int DERATE_PS  = 1875;
  localparam int PERIOD_PS  = 4000;
  localparam int DERATE_CYC = (DERATE_PS + PERIOD_PS - 1) / PERIOD_PS;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] address;
    logic [7:0] opcode;
  } mode_cmd_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } mode_rdata_t;

  typedef enum logic {BURST_IDLE, BURST_RUN} burst_state_t;
endpackage

// ### test/mode_ctrl_model.sv
// controller-side model: mode register commands and burst starts
// assumes one shared clock; requests change just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module mode_ctrl_model
  import dram_mode_pkg::*;
(
  input  wire logic        clock_in,
  input  wire mode_rdata_t read_in,
  output var  mode_cmd_t   command_out,
  output var  logic        burst_start_out,
  output var  logic [3:1]  column_out
);
  logic derate_seen;  // last temperature read asked for derating
  logic limit_seen;   // last temperature read reported a limit
  int   row_extra_ps; // added to every core row timing while derating

  initial begin
    command_out = '0;
    burst_start_out = 1'b0;
    column_out = 3'h0;
    derate_seen = 1'b0;
    limit_seen = 1'b0;
    row_extra_ps = 0;
  end

  // write pulse; released bus shows the inverse so stale values never pass
  task automatic mr_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clock_in);
    #1;
    command_out.write = 1'b1;
    command_out.address = addr;
    command_out.opcode = data;
    @(posedge clock_in);
    #1;
    command_out.write = 1'b0;
    command_out.address = ~addr;
    command_out.opcode = ~data;
  endtask

  // read pulse; the answer stands in the cycle after the taking edge
  task automatic mr_read(input logic [7:0] addr, output logic [7:0] data,
                         output logic valid);
    @(posedge clock_in);
    #1;
    command_out.read = 1'b1;
    command_out.address = addr;
    @(posedge clock_in);
    #1;
    command_out.read = 1'b0;
    command_out.address = ~addr;
    valid = read_in.valid;
    data = read_in.data;
    if (addr == ADDR_TEMP && valid) begin
      derate_seen = (data[2:0] == REF_QTR_DERATE);
      row_extra_ps = derate_seen ? DERATE_PS : 0;
      limit_seen = (data[2:0] == REF_LOW_LIMIT) || (data[2:0] == REF_HIGH_LIMIT);
    end
  endtask

  // no-wrap starts at the last even column of a page or sub-page half
  // would cross an edge in this 16-column view, so they are never sent
  task automatic start_burst(input logic [3:1] col, input logic nowrap);
    if (nowrap && col[2:1] == 2'h3)
      return;
    @(posedge clock_in);
    #1;
    burst_start_out = 1'b1;
    column_out = col;
    @(posedge clock_in);
    #1;
    burst_start_out = 1'b0;
    column_out = ~col;
  endtask
endmodule
`default_nettype wire

// ### test/dram_mode_register_bank_tb_top.sv
// testbench for the mode register bank, controller model on the far side
// assumes the package constants and a 250 MHz command clock
`timescale 1ns/1ps
`default_nettype none
module dram_mode_register_bank_tb_top;
  import dram_mode_pkg::*;
  localparam logic [7:0] TB_MAKER = 8'hA7; // arbitrary value
  localparam logic [7:0] TB_REV   = 8'h4E; // arbitrary value
  logic        clock_in;
  logic        reset_in;
  logic [2:0]  sensor_code_in;
  mode_cmd_t   command_in;
  mode_rdata_t read_out;
  logic        burst_start_in;
  logic [3:1]  column_in;
  logic [3:0]  burst_column_out;
  logic [3:0]  latency_config_out;
  logic [3:0]  drive_strength_out;
  logic        burst_valid_out;
  logic        burst_illegal_out;
  logic        derate_out;
  logic        limit_error_out;
  logic        hot_out;
  int          num_errors;
  int          n_checks;
  int          cycles;

  dram_mode_register_bank #(.MAKER_ID(TB_MAKER), .REVISION_ID(TB_REV)) DUT (
    .clock_in(clock_in), .reset_in(reset_in), .command_in(command_in),
    .read_out(read_out), .sensor_code_in(sensor_code_in),
    .burst_start_in(burst_start_in), .column_in(column_in),
    .burst_column_out(burst_column_out), .burst_valid_out(burst_valid_out),
    .burst_illegal_out(burst_illegal_out), .latency_config_out(latency_config_out),
    .drive_strength_out(drive_strength_out), .derate_out(derate_out),
    .limit_error_out(limit_error_out), .hot_out(hot_out));

  mode_ctrl_model ctrl (
    .clock_in(clock_in), .read_in(read_out), .command_out(command_in),
    .burst_start_out(burst_start_in), .column_out(column_in));

  always #2 clock_in = ~clock_in;

  // a hang counts as a mismatch; the whole run needs well under this
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask

  task automatic read_check(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    ctrl.mr_read(addr, d, v);
    check_bit(v, 1'b1, "read answer");
    check_byte(d, exp, "read data");
  endtask

  task automatic t_reset();
    check_byte({4'h0, latency_config_out}, 8'h01, "latency default");
    check_byte({4'h0, drive_strength_out}, 8'h02, "drive default");
    read_check(ADDR_TEMP, 8'h03);
    read_check(ADDR_MAKER, TB_MAKER);
    read_check(ADDR_REVISION, TB_REV);
    read_check(ADDR_LATENCY, 8'h00);
  endtask

  // every code with junk upper bits; reserved codes must leave the value
  task automatic t_codes();
    logic [3:0] lat;
    logic [3:0] drv;
    lat = 4'h1;
    drv = 4'h2;
    for (int i = 0; i < 16; i++) begin
      ctrl.mr_write(ADDR_LATENCY, {4'hA, 4'(i)});
      ctrl.mr_write(ADDR_DRIVE, {4'h5, 4'(i)});
      if (i >= 1 && i <= 6) lat = 4'(i);
      if (i >= 1 && i <= 7 && i != 5) drv = 4'(i);
      check_byte({4'h0, latency_config_out}, {4'h0, lat}, "latency code");
      check_byte({4'h0, drive_strength_out}, {4'h0, drv}, "drive code");
    end
  endtask

  // each code differs from the last, so every first read shows the flag
  task automatic t_temp();
    logic [2:0] seq [7] = '{3'h6, 3'h0, 3'h7, 3'h1, 3'h2, 3'h5, 3'h3};
    for (int i = 0; i < 7; i++) begin
      sensor_code_in = seq[i];
      repeat (5) @(posedge clock_in);
      #1;
      check_bit(hot_out, seq[i][2], "hot level");
      check_bit(derate_out, seq[i] == 3'h6, "derate level");
      check_bit(limit_error_out, seq[i] == 3'h0 || seq[i] == 3'h7, "limit level");
      read_check(ADDR_TEMP, {5'h10, seq[i]});
      check_bit(ctrl.row_extra_ps == DERATE_PS, seq[i] == 3'h6, "derate applied");
      check_bit(ctrl.limit_seen, seq[i] == 3'h0 || seq[i] == 3'h7, "limit seen");
      read_check(ADDR_TEMP, {5'h00, seq[i]});
    end
  endtask

  // cfg is {no-wrap, interleave, length code}; expected order from the rules
  task automatic do_burst(input logic [4:0] cfg, input logic [3:1] col, input int len,
                          input logic bad);
    logic [3:0] base;
    logic [3:0] mask;
    logic [3:0] exp;
    base = {col, 1'b0};
    mask = 4'(len - 1);
    ctrl.mr_write(ADDR_BURST, {3'h0, cfg});
    ctrl.start_burst(col, cfg[WC_BIT]);
    check_bit(burst_illegal_out, bad, "illegal pulse");
    for (int b = 0; b < len && !bad; b++) begin
      if (cfg[BT_BIT]) exp = base ^ 4'(b);
      else if (cfg[WC_BIT]) exp = base + 4'(b);
      else exp = (base & ~mask) | ((base + 4'(b)) & mask);
      check_bit(burst_valid_out, 1'b1, "beat valid");
      check_byte({4'h0, burst_column_out}, {4'h0, exp}, "beat column");
      @(posedge clock_in);
      #1;
    end
    check_bit(burst_valid_out, 1'b0, "burst over");
  endtask

  task automatic t_bursts();
    do_burst({2'h0, BL4}, 3'h1, 4, 1'b0);
    do_burst({2'h0, BL8}, 3'h3, 8, 1'b0);
    do_burst({2'h1, BL8}, 3'h1, 8, 1'b0);
    do_burst({2'h0, BL16}, 3'h5, 16, 1'b0);
    do_burst({2'h1, BL16}, 3'h0, 16, 1'b1);
    do_burst({2'h2, BL16}, 3'h0, 16, 1'b1);
    do_burst({2'h2, BL8}, 3'h0, 8, 1'b1);
    do_burst({2'h2, BL4}, 3'h2, 4, 1'b0);
  endtask

  initial begin
    clock_in = 1'b0;
    reset_in = 1'b1;
    sensor_code_in = 3'h3;
    num_errors = 0;
    n_checks = 0;
    cycles = 0;
    repeat (5) @(posedge clock_in);
    #1;
    reset_in = 1'b0;
    t_reset();
    t_codes();
    t_temp();
    t_bursts();
    report_and_stop();
  end
endmodule
`default_nettype wire
